// file: src/drs_pkg.sv
// constants shared by the dual output reset supervisor
// assumes a single 40 MHz reference clock and comparator results already digital
//
// What this block does
// - main reset goes low while either voltage comparator reports undervoltage.
// - main reset stays low one timeout after both voltages recover.
// - long-press variant: held button asserts main reset; releases a timeout after release.
// - manual reset output goes low at once when the button goes low.
// - short-press variant: manual reset output holds low one timeout after release.
// - short-press variant: button never touches the main reset.
// - long-press variant: after long press both outputs hold one timeout after release.
// - long-press variant: short press asserts only the manual reset output.
// - supply dips of about 20 us or less are filtered out.
// - extended setup period is a build-time choice of four values.
package drs_pkg;
    // -------------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TIMEOUT_MS = 140;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned GLITCH_US = 20;
    localparam int unsigned GLITCH_CYC = GLITCH_US * (CLK_HZ / 1_000_000);
    // extended setup periods in milliseconds
    localparam int unsigned SETUP_K_MS = 10080;
    localparam int unsigned SETUP_L_MS = 6720;
    localparam int unsigned SETUP_S_MS = 3360;
    localparam int unsigned SETUP_T_MS = 1680;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned GLT_W = 10;
    // variant and setup selection codes
    localparam logic VARIANT_SHORT = 1'b0;
    localparam logic VARIANT_LONG = 1'b1;
    localparam logic [1:0] SETUP_SEL_K = 2'h0;
    localparam logic [1:0] SETUP_SEL_L = 2'h1;
    localparam logic [1:0] SETUP_SEL_S = 2'h2;
    localparam logic [1:0] SETUP_SEL_T = 2'h3;
    // -------------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {DRS_IDLE, DRS_PRESS, DRS_HOLD} drs_btn_t;
endpackage : drs_pkg

// file: src/drs_supervisor.sv
// dual output reset supervisor: main reset and manual reset outputs
// assumes comparator and pushbutton levels are asynchronous to i_ref_clk
`timescale 1ns/10ps
module drs_supervisor
    import drs_pkg::*;
#(
    parameter logic P_VARIANT = VARIANT_LONG,
    parameter logic [1:0] P_SETUP_SEL = SETUP_SEL_T,
    parameter int unsigned P_TIMEOUT_CYC = TIMEOUT_CYC,
    parameter int unsigned P_SETUP_K_CYC = SETUP_K_MS * (CLK_HZ / 1000),
    parameter int unsigned P_SETUP_L_CYC = SETUP_L_MS * (CLK_HZ / 1000),
    parameter int unsigned P_SETUP_S_CYC = SETUP_S_MS * (CLK_HZ / 1000),
    parameter int unsigned P_SETUP_T_CYC = SETUP_T_MS * (CLK_HZ / 1000)
)
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // comparator results, high when voltage is above threshold
    input wire logic i_supply_ok,
    input wire logic i_adjustable_monitor_ok,
    // pushbutton, low when pressed
    input wire logic i_pushbutton_input_n,
    // outputs to the processor
    output logic o_reset_n,
    output logic o_manual_reset_output_n
);
    // -------------------------------------------------------------------------
    // setup period selection
    // -------------------------------------------------------------------------
    localparam int unsigned SETUP_CYC = (P_SETUP_SEL == SETUP_SEL_K) ? P_SETUP_K_CYC :
                                        (P_SETUP_SEL == SETUP_SEL_L) ? P_SETUP_L_CYC :
                                        (P_SETUP_SEL == SETUP_SEL_S) ? P_SETUP_S_CYC :
                                        P_SETUP_T_CYC;

    // -------------------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            // button idle, comparators failing: no false press edge after reset
            sync1 <= 3'h4;
            sync2 <= 3'h4;
        end
        else
        begin
            sync1 <= {i_pushbutton_input_n, i_adjustable_monitor_ok, i_supply_ok};
            sync2 <= sync1;
        end
    end
    logic btn_n;
    assign btn_n = sync2[2];

    // -------------------------------------------------------------------------
    // glitch filter: low must persist past the glitch window
    // -------------------------------------------------------------------------
    logic [GLT_W-1:0] glt_cnt;
    logic [GLT_W-1:0] next_glt_cnt;
    logic volt_ok;
    logic next_volt_ok;
    always_comb
    begin
        next_glt_cnt = '0;
        next_volt_ok = volt_ok;
        if (sync2[1:0] != 2'h3)
        begin
            // dips shorter than the window never reach the reset logic
            if (glt_cnt >= GLT_W'(GLITCH_CYC))
                next_volt_ok = 1'b0;
            else
                next_glt_cnt = glt_cnt + GLT_W'(1);
        end
        else
            next_volt_ok = 1'b1;
    end

    // -------------------------------------------------------------------------
    // voltage timeout counter
    // -------------------------------------------------------------------------
    logic [CNT_W-1:0] vcnt;
    logic [CNT_W-1:0] next_vcnt;
    logic vrst;
    logic next_vrst;
    always_comb
    begin
        next_vcnt = '0;
        next_vrst = vrst;
        if (!volt_ok)
            next_vrst = 1'b1;
        else if (vrst)
        begin
            if (vcnt >= CNT_W'(P_TIMEOUT_CYC - 1))
                next_vrst = 1'b0;
            else
                next_vcnt = vcnt + CNT_W'(1);
        end
    end

    // -------------------------------------------------------------------------
    // pushbutton state machine
    // -------------------------------------------------------------------------
    drs_btn_t bstate;
    drs_btn_t next_bstate;
    logic [CNT_W-1:0] bcnt;
    logic [CNT_W-1:0] next_bcnt;
    logic long_press;
    logic next_long_press;
    always_comb
    begin
        next_bstate = bstate;
        next_bcnt = bcnt;
        next_long_press = long_press;
        case (bstate)
            DRS_IDLE:
            begin
                next_bcnt = '0;
                next_long_press = 1'b0;
                if (!btn_n)
                    next_bstate = DRS_PRESS;
            end
            DRS_PRESS:
            begin
                if (btn_n)
                begin
                    next_bstate = DRS_HOLD;
                    next_bcnt = '0;
                end
                else if (P_VARIANT == VARIANT_LONG && bcnt >= CNT_W'(SETUP_CYC - 1))
                    next_long_press = 1'b1;
                else
                    next_bcnt = bcnt + CNT_W'(1);
            end
            DRS_HOLD:
            begin
                if (!btn_n)
                begin
                    // re-press restarts the press measurement
                    next_bstate = DRS_PRESS;
                    next_bcnt = '0;
                    next_long_press = 1'b0;
                end
                else if (bcnt >= CNT_W'(P_TIMEOUT_CYC - 1))
                    next_bstate = DRS_IDLE;
                else
                    next_bcnt = bcnt + CNT_W'(1);
            end
            default:
                next_bstate = DRS_IDLE;
        endcase
    end

    // -------------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            glt_cnt <= '0;
            volt_ok <= 1'b0;
            vcnt <= '0;
            vrst <= 1'b1;
            bstate <= DRS_HOLD;
            bcnt <= '0;
            long_press <= 1'b0;
        end
        else
        begin
            glt_cnt <= next_glt_cnt;
            volt_ok <= next_volt_ok;
            vcnt <= next_vcnt;
            vrst <= next_vrst;
            bstate <= next_bstate;
            bcnt <= next_bcnt;
            long_press <= next_long_press;
        end
    end

    // immediate assertion path bypasses the state register
    assign o_manual_reset_output_n = btn_n && (bstate == DRS_IDLE);
    // short variant never sets long_press, so the button stays off the main reset
    assign o_reset_n = !(vrst || long_press);

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    // length of the current press, kept apart from the state machine's own counter
    logic [CNT_W-1:0] chk_low_len;
    logic [CNT_W-1:0] next_chk_low_len;
    always_comb
    begin
        next_chk_low_len = '0;
        if (!btn_n && chk_low_len != '1)
            next_chk_low_len = chk_low_len + CNT_W'(1);
        else if (!btn_n)
            next_chk_low_len = chk_low_len;
    end
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            chk_low_len <= '0;
        else
            chk_low_len <= next_chk_low_len;
    end

    a_undervolt_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !volt_ok |=> !o_reset_n)
        else $error("main reset not asserted on undervoltage");
    a_mr_immediate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_pushbutton_input_n |-> ##2 !o_manual_reset_output_n)
        else $error("manual reset output not immediate");
    a_vrst_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(volt_ok) |-> !o_reset_n [*8])
        else $error("main reset released too early");
    a_short_only: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        P_VARIANT == VARIANT_SHORT && $fell(o_reset_n) |-> !$past(volt_ok))
        else $error("button affected main reset in short variant");
    a_short_press: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(long_press) |-> chk_low_len >= CNT_W'(SETUP_CYC))
        else $error("main reset asserted before the setup period");
    a_mr_timeout: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(btn_n) |-> !o_manual_reset_output_n [*8])
        else $error("manual reset output released early");
    a_long_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        long_press && $rose(btn_n) |-> !o_reset_n [*8])
        else $error("main reset released early after long press");
    a_glitch_ignore: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        volt_ok && sync2[1:0] != 2'h3 && $past(sync2[1:0]) == 2'h3 |=> volt_ok [*8])
        else $error("short dip dropped the voltage flag");
endmodule : drs_supervisor

// file: tb/drs_cpu_model.sv
// processor model that takes the main reset and the interrupt line of the supervisor
// assumes both lines are active-low levels that the supervisor drives push-pull
`timescale 1ns/10ps
module drs_cpu_model
(
    // clock
    input wire logic i_ref_clk,
    // lines from the supervisor
    input wire logic i_reset_n,
    input wire logic i_nmi_n,
    // interrupts taken while running
    output logic [7:0] o_nmi_count
);
    logic nmi_q = 1'b0;
    logic [7:0] nmi_total = 8'h00;

    assign o_nmi_count = nmi_total;

    // a held core cannot service an interrupt, so only count edges while running
    always @(posedge i_ref_clk)
    begin
        nmi_q <= i_nmi_n;
        if (nmi_q && !i_nmi_n && i_reset_n)
            nmi_total <= nmi_total + 8'h01;
    end
endmodule : drs_cpu_model

// file: tb/drs_supervisor_tb_top.sv
// testbench for the supervisor: long-press and short-press builds side by side
// assumes shortened timeout and setup counts; glitch filter keeps its real length
`timescale 1ns/10ps
module drs_supervisor_tb_top;
    import drs_pkg::*;
    // timeout longer than the glitch window so a dip can land inside it
    localparam int unsigned TO = 2000;
    localparam int unsigned SU = 200;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic sup_ok = 1'b1;
    logic adj_ok = 1'b1;
    logic btn_n = 1'b1;
    logic rst_l, mr_l, rst_s, mr_s;
    logic [7:0] nmi_cnt;
    int failures = 0;
    int checked = 0;
    int n;

    drs_supervisor #(.P_VARIANT(VARIANT_LONG), .P_SETUP_SEL(SETUP_SEL_T), .P_TIMEOUT_CYC(TO),
        .P_SETUP_K_CYC(SU), .P_SETUP_L_CYC(SU), .P_SETUP_S_CYC(SU), .P_SETUP_T_CYC(SU)) dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_supply_ok(sup_ok),
        .i_adjustable_monitor_ok(adj_ok), .i_pushbutton_input_n(btn_n),
        .o_reset_n(rst_l), .o_manual_reset_output_n(mr_l));
    drs_supervisor #(.P_VARIANT(VARIANT_SHORT), .P_TIMEOUT_CYC(TO)) dut_short (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_supply_ok(sup_ok),
        .i_adjustable_monitor_ok(adj_ok), .i_pushbutton_input_n(btn_n),
        .o_reset_n(rst_s), .o_manual_reset_output_n(mr_s));
    drs_cpu_model cpu (.i_ref_clk(i_ref_clk), .i_reset_n(rst_l), .i_nmi_n(mr_l),
        .o_nmi_count(nmi_cnt));

    initial forever #12.5 i_ref_clk = ~i_ref_clk;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    task give_verdict;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic pick(input int w);
        return (w == 0) ? rst_l : (w == 1) ? mr_l : (w == 2) ? rst_s : mr_s;
    endfunction : pick

    // bounded wait for an output level; n returns the cycles it took
    task wait_out(input int w, input logic v, input int max, output int cnt);
        cnt = 0;
        while (pick(w) !== v && cnt < max)
        begin
            @(posedge i_ref_clk);
            #1;
            cnt++;
        end
        check(pick(w), v);
        if (pick(w) !== v)
            give_verdict();
    endtask : wait_out

    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------
    task t_powerup;
        wait_out(0, 1'b1, TO + 20, n);
        check(32'(n >= TO), 32'h1);
        check(rst_s, 1'b1);
        check(mr_l, 1'b1);
        $display("powerup test done");
    endtask : t_powerup

    task t_short_press;
        @(posedge i_ref_clk);
        btn_n <= 1'b0;
        wait_out(1, 1'b0, 3, n);
        wait_out(3, 1'b0, 1, n);
        repeat (20) @(posedge i_ref_clk);
        btn_n <= 1'b1;
        wait_out(1, 1'b1, TO + 10, n);
        check(32'(n >= TO), 32'h1);
        wait_out(3, 1'b1, 3, n);
        check(rst_l, 1'b1);
        check(nmi_cnt, 8'h01);
        $display("short press test done");
    endtask : t_short_press

    task t_long_press;
        @(posedge i_ref_clk);
        btn_n <= 1'b0;
        wait_out(0, 1'b0, SU + 10, n);
        check(32'(n >= SU), 32'h1);
        check(mr_l, 1'b0);
        check(rst_s, 1'b1);
        @(posedge i_ref_clk);
        btn_n <= 1'b1;
        wait_out(0, 1'b1, TO + 10, n);
        check(32'(n >= TO), 32'h1);
        wait_out(1, 1'b1, 3, n);
        check(rst_s, 1'b1);
        $display("long press test done");
    endtask : t_long_press

    task t_brownout;
        @(posedge i_ref_clk);
        sup_ok <= 1'b0;
        repeat (400) @(posedge i_ref_clk);
        sup_ok <= 1'b1;
        repeat (900) @(posedge i_ref_clk);
        #1;
        check({rst_l, rst_s}, 2'h3);
        @(posedge i_ref_clk);
        adj_ok <= 1'b0;
        wait_out(0, 1'b0, GLITCH_CYC + 20, n);
        check(32'(n >= GLITCH_CYC), 32'h1);
        wait_out(2, 1'b0, 5, n);
        @(posedge i_ref_clk);
        adj_ok <= 1'b1;
        repeat (TO / 4) @(posedge i_ref_clk);
        sup_ok <= 1'b0;
        repeat (1000) @(posedge i_ref_clk);
        sup_ok <= 1'b1;
        #1;
        check(rst_l, 1'b0);
        wait_out(0, 1'b1, TO + 20, n);
        check(32'(n >= TO), 32'h1);
        $display("brownout test done");
    endtask : t_brownout

    initial
    begin
        repeat (4) @(posedge i_ref_clk);
        #1;
        check({rst_l, mr_l, rst_s, mr_s}, 4'h0);
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        t_powerup();
        t_short_press();
        t_long_press();
        t_brownout();
        give_verdict();
    end
endmodule : drs_supervisor_tb_top
